//--- src/hbi_consts.svh
`ifndef HBI_CONSTS_SVH
`define HBI_CONSTS_SVH

// ---------------------------------------------------------------
// configuration straps
// ---------------------------------------------------------------
`define HBI_CNF_W          9
`define HBI_CNF_SER_FALL   5'h10
`define HBI_CNF_SER_RISE   5'h18
`define HBI_CNF_INDIRECT   2
`define HBI_CNF_ENDIAN     5
`define HBI_CNF_DUALCS     6
`define HBI_CNF_SRC_HI     8
`define HBI_CNF_SRC_LO     7
`define HBI_STRAP_SETTLE   2'h2

// ---------------------------------------------------------------
// indirect port decode
// ---------------------------------------------------------------
`define HBI_PORT_INDEX     2'h0
`define HBI_PORT_STATUS    2'h1
`define HBI_PORT_DATA      2'h2
`define HBI_IDX_WRITE_BIT  0

// ---------------------------------------------------------------
// serial commands
// ---------------------------------------------------------------
`define HBI_CMD_WRITE      16'h0000
`define HBI_CMD_READ       16'h4000
`define HBI_CMD_END        16'h8000
`define HBI_CMD_STATUS     16'hC000
`define HBI_SER_LAST       5'h0F
`define HBI_ADDR_STEP      16'h0002

// ---------------------------------------------------------------
// local registers, byte addresses
// ---------------------------------------------------------------
`define HBI_REG_HOST_INT   21'h000020
`define HBI_REG_TMO_CTRL   21'h000024
`define HBI_REG_ERR_STAT   21'h000026
`define HBI_REG_ERR_EN     21'h000028
`define HBI_REG_CLK_EN     21'h000462
`define HBI_REG_WDOG       21'h000472
`define HBI_TMO_EN_BIT     7
`define HBI_CLK_PCLK_BIT   3
`define HBI_CLK_HCLK_BIT   1
`define HBI_WDOG_DIS_BIT   0
`define HBI_WDOG_IDIS_BIT  1
`define HBI_WDOG_FLAG_BIT  2
`define HBI_WAIT_LIMIT     2000

`endif

//--- src/hbi_pkg.sv
package hbi_pkg;

    typedef enum logic [1:0] {
        HBI_SER_IDLE,
        HBI_SER_ADDR,
        HBI_SER_DATA
    } hbi_ser_e;

    typedef enum logic [1:0] {
        HBI_MODE_WRITE,
        HBI_MODE_READ,
        HBI_MODE_STATUS
    } hbi_mode_e;

    typedef struct packed {
        logic [56:0] sync1;
        logic [56:0] sync2;
        logic [1:0]  strap_cnt;
        logic        strap_done;
        logic [8:0]  straps;
        logic        sck_prev;
        logic        scs_prev;
        logic        src_prev;
        logic        par_act;
        logic        par_done;
        logic [15:0] rdata;
        logic        data_oe;
        logic        wait_n;
        logic [15:0] index;
        logic        acc_req;
        logic        acc_abort;
        logic        acc_pend;
        logic        acc_ser;
        logic        acc_mem;
        logic        acc_write;
        logic [19:0] acc_addr;
        logic [15:0] acc_wdata;
        logic        pf_valid;
        logic [19:0] pf_last;
        logic [15:0] pf_word;
        logic [7:0]  tmo_cnt;
        logic        host_int;
        logic [7:0]  tmo_ctrl;
        logic [1:0]  err_stat;
        logic [1:0]  err_en;
        logic        pclk_en;
        logic        hclk_en;
        logic        wdog_dis;
        logic        wdog_idis;
        logic        wdog_flag;
        logic [11:0] wait_cnt;
        logic        bus_reset;
        hbi_ser_e    ser_state;
        hbi_mode_e   ser_mode;
        logic [4:0]  ser_cnt;
        logic [15:0] ser_rx;
        logic [15:0] tx;
        logic [15:0] ser_addr;
        logic [15:0] captured;
        logic        so_oe;
    } hbi_state_s;

endpackage

//--- src/hbi_host_port.sv
// Operation
// [RQ1] straps are captured once after reset release; later changes ignored
// [RQ2] single select: select enables, space pin picks space; dual: two selects
// [RQ3] endian strap low gives little endian, high gives big endian lanes
// [RQ4] big endian swaps memory data only; host swaps register bytes itself
// [RQ5] direct mode takes address pins 20..1; indirect takes index register
// [RQ6] serial strap 10000b samples on falling edge, 11000b on rising
// [RQ7] enabled memory access longer than 7-bit limit sets host interrupt flag
// [RQ8] enabled read/write error flags set on timeout; cleared by writing one
// [RQ9] wait held beyond 2000 strap-selected source clocks is a wait timeout
// [RQ10] reset-disable clear: wait timeout resets unit, sets flag if enabled
// [RQ11] writing one to interrupt-disable clears the wait timeout flag
// [RQ12] port decode: 00 index, 01 status read, 10 data, 11 reserved
// [RQ13] index bits 15..1 hold address, bit 0 picks data port direction
// [RQ14] status bit 0 shows memory controller busy; host checks once
// [RQ15] data port moves 16-bit data to address held in index bits 15..1
// [RQ16] host rewrites address after an error; failed location is lost
// [RQ17] memory read fetches a burst; next +2 read answered from buffer
// [RQ18] prefetch buffer dropped on memory write or non-sequential read
// [RQ19] serial words are 16 bits, MSB first, clock at most 16 MHz
// [RQ20] select low means command; codes write, read, end, status
// [RQ21] status command returns memory status bit over serial link
// [RQ22] serial output driven only while serial select is low
// [RQ23] host drops select before a command; high gap at least one clock
// [RQ24] serial read data word returns previous capture and reads again
// [RQ25] serial burst writes step the address by two bytes per word
// [RQ26] single write: write command, address, one data word, end command
`timescale 1ns/100ps
`default_nettype none
`include "hbi_consts.svh"

module hbi_host_port #(
    parameter int WAIT_LIMIT = `HBI_WAIT_LIMIT
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    input  wire logic [`HBI_CNF_W-1:0] i_config_straps,
    input  wire logic                  i_chip_select_n,
    input  wire logic                  i_space_select,
    input  wire logic                  i_read_n,
    input  wire logic                  i_write_n,
    input  wire logic [20:1]           i_host_address_pins,
    input  wire logic [15:0]           i_data,
    output var  logic [15:0]           o_data,
    output var  logic                  o_data_oe,
    output var  logic                  o_wait_n,
    input  wire logic                  i_sck,
    input  wire logic                  i_si,
    input  wire logic                  i_cmd_data_select,
    input  wire logic                  i_serial_select_n,
    output var  logic                  o_so,
    output var  logic                  o_so_oe,
    input  wire logic [3:0]            i_source_clocks,
    output var  logic                  o_acc_req,
    output var  logic                  o_acc_abort,
    output var  logic                  o_acc_mem,
    output var  logic                  o_acc_write,
    output var  logic [19:0]           o_acc_addr,
    output var  logic [15:0]           o_acc_wdata,
    input  wire logic                  i_acc_done,
    input  wire logic [31:0]           i_acc_rdata,
    input  wire logic                  i_mem_busy,
    output var  logic                  o_host_int,
    output var  logic                  o_bus_reset
);

    hbi_pkg::hbi_state_s st;
    hbi_pkg::hbi_state_s next_st;

    logic                  p_cs_n;
    logic                  p_space;
    logic                  p_rd_n;
    logic                  p_wr_n;
    logic [20:1]           p_addr;
    logic [15:0]           p_data;
    logic                  p_sck;
    logic                  p_si;
    logic                  p_sa0;
    logic                  p_scs_n;
    logic [3:0]            p_src;
    logic [`HBI_CNF_W-1:0] p_straps;

    assign {p_cs_n, p_space, p_rd_n, p_wr_n, p_addr, p_data,
            p_sck, p_si, p_sa0, p_scs_n, p_src, p_straps} = st.sync2;

    function automatic logic [15:0] swap(input logic [15:0] v);
        swap = {v[7:0], v[15:8]};
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic        serial;
        logic        on_fall;
        logic        big;
        logic        sel;
        logic        mem;
        logic        strobe;
        logic        go;
        logic        go_ser;
        logic        go_mem;
        logic        go_wr;
        logic [19:0] go_addr;
        logic [15:0] go_data;
        logic [20:0] bya;
        logic [15:0] val;
        logic        hit;
        logic        samp;
        logic        outp;
        logic        src_edge;
        logic [15:0] word;
        next_st = st;
        serial = 1'b0;
        on_fall = 1'b0;
        big = 1'b0;
        sel = 1'b0;
        mem = 1'b0;
        strobe = 1'b0;
        go = 1'b0;
        go_ser = 1'b0;
        go_mem = 1'b0;
        go_wr = 1'b0;
        go_addr = '0;
        go_data = '0;
        bya = '0;
        val = '0;
        hit = 1'b0;
        samp = 1'b0;
        outp = 1'b0;
        src_edge = 1'b0;
        word = '0;
        next_st.acc_req = 1'b0;
        next_st.acc_abort = 1'b0;
        next_st.bus_reset = 1'b0;
        next_st.sync1 = {i_chip_select_n, i_space_select, i_read_n,
                         i_write_n, i_host_address_pins, i_data, i_sck,
                         i_si, i_cmd_data_select, i_serial_select_n,
                         i_source_clocks, i_config_straps};
        next_st.sync2 = st.sync1;

        // ---------------------------------------------------------------
        // strap capture
        // ---------------------------------------------------------------
        if (!st.strap_done) begin
            if (st.strap_cnt == `HBI_STRAP_SETTLE) begin
                next_st.straps = p_straps; // RQ1
                next_st.strap_done = 1'b1; // RQ1
            end else begin
                next_st.strap_cnt = st.strap_cnt + 2'h1;
            end
        end
        serial = (st.straps[4:0] == `HBI_CNF_SER_FALL) ||
                 (st.straps[4:0] == `HBI_CNF_SER_RISE);
        on_fall = st.straps[4:0] == `HBI_CNF_SER_FALL; // RQ6
        big = st.straps[`HBI_CNF_ENDIAN]; // RQ3

        // ---------------------------------------------------------------
        // parallel host cycle
        // ---------------------------------------------------------------
        if (st.straps[`HBI_CNF_DUALCS]) begin
            sel = !p_cs_n || !p_space; // RQ2
            mem = !p_cs_n; // RQ2
        end else begin
            sel = !p_cs_n; // RQ2
            mem = p_space; // RQ2
        end
        strobe = !p_rd_n || !p_wr_n;
        if (st.strap_done && !serial) begin
            if (!st.par_act && sel && strobe) begin
                next_st.par_act = 1'b1;
                next_st.par_done = 1'b1;
                next_st.rdata = '0;
                if (st.straps[`HBI_CNF_INDIRECT]) begin
                    case (p_addr[2:1]) // RQ12
                        `HBI_PORT_INDEX: begin
                            if (!p_rd_n) next_st.rdata = st.index;
                            else next_st.index = p_data;
                        end
                        `HBI_PORT_STATUS: begin
                            if (!p_rd_n) next_st.rdata = {15'h0000, i_mem_busy}; // RQ14
                        end
                        `HBI_PORT_DATA: begin
                            // direction must match index bit 0
                            go = (!p_wr_n) == st.index[`HBI_IDX_WRITE_BIT]; // RQ13
                            go_addr = {5'h00, st.index[15:1]}; // RQ15
                        end
                        default: begin
                            next_st.rdata = '0;
                        end
                    endcase
                end else begin
                    go = 1'b1;
                    go_addr = p_addr; // RQ5
                end
                go_mem = mem;
                go_wr = !p_wr_n;
                go_data = p_data;
            end else if (st.par_act && !strobe) begin
                next_st.par_act = 1'b0;
            end
        end
        next_st.data_oe = st.par_act && !p_rd_n && sel;

        // ---------------------------------------------------------------
        // serial link
        // ---------------------------------------------------------------
        next_st.sck_prev = p_sck;
        next_st.scs_prev = p_scs_n;
        next_st.so_oe = st.strap_done && serial && !p_scs_n; // RQ22
        samp = on_fall ? (st.sck_prev && !p_sck) : (!st.sck_prev && p_sck);
        outp = on_fall ? (!st.sck_prev && p_sck) : (st.sck_prev && !p_sck);
        if (!st.strap_done || !serial || p_scs_n ||
            (st.scs_prev && !p_scs_n)) begin
            next_st.ser_cnt = '0;
        end else if (samp) begin
            word = {st.ser_rx[14:0], p_si}; // RQ19
            next_st.ser_rx = word;
            next_st.ser_cnt = st.ser_cnt + 5'h01;
            if (st.ser_cnt == `HBI_SER_LAST) begin
                next_st.ser_cnt = '0;
                next_st.tx = st.captured;
                if (!p_sa0) begin
                    case (word) // RQ20
                        `HBI_CMD_WRITE: begin
                            next_st.ser_state = hbi_pkg::HBI_SER_ADDR;
                            next_st.ser_mode = hbi_pkg::HBI_MODE_WRITE;
                        end
                        `HBI_CMD_READ: begin
                            next_st.ser_state = hbi_pkg::HBI_SER_ADDR;
                            next_st.ser_mode = hbi_pkg::HBI_MODE_READ;
                        end
                        `HBI_CMD_STATUS: begin
                            next_st.ser_state = hbi_pkg::HBI_SER_IDLE;
                            next_st.ser_mode = hbi_pkg::HBI_MODE_STATUS;
                            next_st.tx = {15'h0000, i_mem_busy}; // RQ21
                        end
                        default: begin
                            next_st.ser_state = hbi_pkg::HBI_SER_IDLE;
                        end
                    endcase
                end else begin
                    case (st.ser_state)
                        hbi_pkg::HBI_SER_ADDR: begin
                            next_st.ser_addr = word;
                            next_st.ser_state = hbi_pkg::HBI_SER_DATA;
                        end
                        hbi_pkg::HBI_SER_DATA: begin
                            go = !st.acc_pend;
                            go_ser = 1'b1;
                            go_addr = {5'h00, st.ser_addr[15:1]};
                            go_wr = st.ser_mode == hbi_pkg::HBI_MODE_WRITE;
                            go_data = word;
                            next_st.ser_addr = st.ser_addr + `HBI_ADDR_STEP; // RQ25
                        end
                        default: begin
                            next_st.ser_state = hbi_pkg::HBI_SER_IDLE;
                        end
                    endcase
                end
            end
        end else if (outp && st.ser_cnt != 5'h00) begin
            next_st.tx = {st.tx[14:0], 1'b0}; // RQ19
        end

        // ---------------------------------------------------------------
        // launch: local register, prefetch hit or internal access
        // ---------------------------------------------------------------
        bya = {go_addr, 1'b0};
        if (go && !go_mem) begin
            hit = 1'b1;
            case (bya)
                `HBI_REG_HOST_INT: begin
                    val = {15'h0000, st.host_int};
                    if (go_wr && go_data[0]) next_st.host_int = 1'b0;
                end
                `HBI_REG_TMO_CTRL: begin
                    val = {8'h00, st.tmo_ctrl};
                    if (go_wr) next_st.tmo_ctrl = go_data[7:0];
                end
                `HBI_REG_ERR_STAT: begin
                    val = {14'h0000, st.err_stat};
                    if (go_wr) next_st.err_stat = st.err_stat & ~go_data[1:0]; // RQ8
                end
                `HBI_REG_ERR_EN: begin
                    val = {14'h0000, st.err_en};
                    if (go_wr) next_st.err_en = go_data[1:0];
                end
                `HBI_REG_CLK_EN: begin
                    val = '0;
                    val[`HBI_CLK_PCLK_BIT] = st.pclk_en;
                    val[`HBI_CLK_HCLK_BIT] = st.hclk_en;
                    if (go_wr) begin
                        next_st.pclk_en = go_data[`HBI_CLK_PCLK_BIT];
                        next_st.hclk_en = go_data[`HBI_CLK_HCLK_BIT];
                    end
                end
                `HBI_REG_WDOG: begin
                    val = {13'h0000, st.wdog_flag, st.wdog_idis, st.wdog_dis};
                    if (go_wr) begin
                        next_st.wdog_dis = go_data[`HBI_WDOG_DIS_BIT];
                        next_st.wdog_idis = go_data[`HBI_WDOG_IDIS_BIT];
                        if (go_data[`HBI_WDOG_IDIS_BIT]) next_st.wdog_flag = 1'b0; // RQ11
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end else if (go && !go_wr && st.pf_valid &&
                     go_addr == st.pf_last + 20'h00001) begin
            hit = 1'b1; // RQ17
            val = st.pf_word;
            next_st.pf_valid = 1'b0;
            next_st.pf_last = go_addr;
        end
        if (go && hit) begin
            if (go_ser) {next_st.captured, next_st.tx} = {2{val}};
            else next_st.rdata = val;
        end else if (go) begin
            next_st.par_done = go_ser ? st.par_done : 1'b0;
            next_st.acc_req = 1'b1;
            next_st.acc_pend = 1'b1;
            next_st.acc_ser = go_ser;
            next_st.acc_mem = go_mem;
            next_st.acc_write = go_wr;
            next_st.acc_addr = go_addr;
            next_st.acc_wdata = (go_mem && big) ? swap(go_data) : go_data; // RQ4
            next_st.tmo_cnt = '0;
            if (go_mem) next_st.pf_valid = 1'b0; // RQ18
        end

        // ---------------------------------------------------------------
        // completion and host access timeout
        // ---------------------------------------------------------------
        if (st.acc_pend && i_acc_done) begin
            val = (st.acc_mem && big) ? swap(i_acc_rdata[15:0])
                                      : i_acc_rdata[15:0]; // RQ4
            next_st.acc_pend = 1'b0;
            if (st.acc_mem && !st.acc_write) begin
                next_st.pf_word = big ? swap(i_acc_rdata[31:16])
                                      : i_acc_rdata[31:16]; // RQ17
                next_st.pf_valid = 1'b1;
                next_st.pf_last = st.acc_addr;
            end
            if (st.acc_ser) begin
                next_st.captured = val; // RQ24
                if (st.ser_cnt == 5'h00) next_st.tx = val;
            end else begin
                next_st.rdata = val;
                next_st.par_done = 1'b1;
            end
        end else if (st.acc_pend && st.acc_mem) begin
            if (st.tmo_cnt != 8'hFF) next_st.tmo_cnt = st.tmo_cnt + 8'h01;
            if (st.tmo_ctrl[`HBI_TMO_EN_BIT] && st.pclk_en && st.hclk_en &&
                st.tmo_cnt > {1'b0, st.tmo_ctrl[6:0]}) begin
                next_st.host_int = 1'b1; // RQ7
                next_st.err_stat = next_st.err_stat |
                    (st.err_en & {st.acc_write, !st.acc_write}); // RQ8
                next_st.acc_pend = 1'b0;
                next_st.acc_abort = 1'b1;
                next_st.par_done = 1'b1;
                next_st.rdata = '0;
            end
        end

        // ---------------------------------------------------------------
        // wait length watchdog on the selected source clock
        // ---------------------------------------------------------------
        next_st.src_prev = p_src[st.straps[`HBI_CNF_SRC_HI:`HBI_CNF_SRC_LO]]; // RQ9
        src_edge = !st.src_prev && next_st.src_prev;
        if (st.wait_n) begin
            next_st.wait_cnt = '0;
        end else if (src_edge) begin
            next_st.wait_cnt = st.wait_cnt + 12'h001;
            if (st.wait_cnt == 12'(WAIT_LIMIT) && !st.wdog_dis) begin
                next_st.bus_reset = 1'b1; // RQ10
                if (!st.wdog_idis) next_st.wdog_flag = 1'b1; // RQ10
                next_st.acc_pend = 1'b0;
                next_st.acc_abort = st.acc_pend;
                next_st.par_done = 1'b1;
                next_st.wait_cnt = '0;
            end
        end
        next_st.wait_n = !(next_st.par_act && !next_st.par_done); // RQ9
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st <= '0;
            st.wait_n <= 1'b1;
            st.wdog_dis <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_data = st.rdata;
    assign o_data_oe = st.data_oe;
    assign o_wait_n = st.wait_n;
    assign o_so = st.tx[15];
    assign o_so_oe = st.so_oe;
    assign o_acc_req = st.acc_req;
    assign o_acc_abort = st.acc_abort;
    assign o_acc_mem = st.acc_mem;
    assign o_acc_write = st.acc_write;
    assign o_acc_addr = st.acc_addr;
    assign o_acc_wdata = st.acc_wdata;
    assign o_host_int = st.host_int;
    assign o_bus_reset = st.bus_reset;

endmodule
`default_nettype wire

//--- bench/hbi_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_mem_model (
    input  wire logic        i_clock,
    input  wire logic        i_req,
    input  wire logic [19:0] i_addr,
    input  wire logic        i_stall,
    output var  logic        o_done = 1'b0,
    output var  logic [31:0] o_rdata = 32'h0000_0000
);
    logic [2:0] pipe = 3'h0;
    always @(posedge i_clock) begin
        pipe <= {pipe[1:0], i_req & ~i_stall};
        o_done <= pipe[2];
        // burst of two words, idle bus toggles
        o_rdata <= pipe[2] ? {i_addr[15:0] + 16'h1, i_addr[15:0]}
                           : ~o_rdata;
    end
endmodule
`default_nettype wire

//--- bench/hbi_host_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_host_port_sva (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_read_n,
    input wire logic i_serial_select_n,
    input wire logic i_acc_done,
    input wire logic o_data_oe,
    input wire logic o_wait_n,
    input wire logic o_so_oe,
    input wire logic o_acc_req,
    input wire logic o_acc_abort,
    input wire logic o_bus_reset
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence sel_low;  !i_serial_select_n [*5]; endsequence
    sequence sel_high; i_serial_select_n [*5]; endsequence
    a_so_drive_low: assert property (sel_low |=> o_so_oe)
        else $error("serial out idle while selected");
    a_so_float_high: assert property (sel_high |=> !o_so_oe)
        else $error("serial out driven while deselected");
    a_bus_quiet_idle: assert property (i_read_n [*5] |=> !o_data_oe)
        else $error("data bus driven without read");
    a_req_one_cycle: assert property (o_acc_req |=> !o_acc_req)
        else $error("request longer than one cycle");
    a_abort_one_cycle: assert property (o_acc_abort |=> !o_acc_abort)
        else $error("abort longer than one cycle");
    a_done_ends_wait: assert property (i_acc_done && !o_wait_n |=> o_wait_n)
        else $error("wait held after completion");
    a_abort_ends_wait: assert property (o_acc_abort |-> ##[0:2] o_wait_n)
        else $error("wait held after abort");
    a_wdog_after_wait: assert property ($rose(o_bus_reset) |-> !$past(o_wait_n))
        else $error("bus reset without wait");
endmodule
bind hbi_host_port hbi_host_port_sva sva (.*);
`default_nettype wire

//--- bench/hbi_host_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module hbi_host_port_test;
    logic i_clock = 1'b0, i_reset = 1'b1, i_chip_select_n = 1'b1;
    logic i_space_select = 1'b0, i_read_n = 1'b1, i_write_n = 1'b1;
    logic i_sck = 1'b0, i_si = 1'b0, i_cmd_data_select = 1'b0;
    logic i_serial_select_n = 1'b1, i_mem_busy = 1'b0, stall = 1'b0;
    logic i_acc_done, o_data_oe, o_wait_n, o_so, o_so_oe, o_acc_req;
    logic o_acc_abort, o_acc_mem, o_acc_write, o_host_int, o_bus_reset;
    logic [8:0]  i_config_straps = 9'h004;
    logic [20:1] i_host_address_pins = 20'h00000;
    logic [15:0] i_data = 16'h0000, o_data, o_acc_wdata, got, n0;
    logic [15:0] reqs = 16'h0000;
    logic [3:0]  i_source_clocks = 4'h0;
    logic [31:0] i_acc_rdata;
    logic [19:0] o_acc_addr;
    int          miscompares = 0, total_checks = 0;
    hbi_host_port #(.WAIT_LIMIT(20)) uut (.*);
    hbi_mem_model mem (.i_clock(i_clock), .i_req(o_acc_req),
        .i_addr(o_acc_addr), .i_stall(stall), .o_done(i_acc_done),
        .o_rdata(i_acc_rdata));
    always #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) i_source_clocks <= i_source_clocks + 4'h1;
    always @(posedge i_clock) if (o_acc_req === 1'b1) reqs <= reqs + 16'h1;
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic par(input logic w, m, input logic [1:0] p,
                       input logic [15:0] d);
        int n = 0;
        {i_chip_select_n, i_space_select, i_read_n, i_write_n} <= {1'b0, m, w, !w};
        {i_host_address_pins, i_data} <= {18'h00000, p, d};
        repeat (3) @(posedge i_clock);
        #1;
        while (o_wait_n !== 1'b1 && n < 300) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        got = o_data;
        if (n == 300) chk(16'h0, 16'h1);
        if (n == 300) test_done;
        @(posedge i_clock);
        {i_chip_select_n, i_read_n, i_write_n} <= 3'h7;
        repeat (4) @(posedge i_clock);
    endtask
    task automatic wreg(input logic [15:0] a, d);
        par(1'b1, 1'b0, 2'h0, a | 16'h0001);
        par(1'b1, 1'b0, 2'h2, d);
    endtask
    task automatic rreg(input logic [15:0] a, e, input logic m);
        par(1'b1, 1'b0, 2'h0, a);
        par(1'b0, m, 2'h2, 16'h0000);
        chk(got, e);
    endtask
    task automatic sword(input logic c, input logic [15:0] w);
        i_cmd_data_select <= c;
        for (int b = 15; b >= 0; b--) begin
            i_si <= w[b];
            repeat (4) @(posedge i_clock);
            i_sck <= 1'b1;
            got[b] = o_so;
            repeat (4) @(posedge i_clock);
            i_sck <= 1'b0;
        end
        repeat (16) @(posedge i_clock);
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        repeat (6) @(posedge i_clock);
        wreg(16'h0024, 16'h0085);
        rreg(16'h0024, 16'h0085, 1'b0);
        par(1'b0, 1'b0, 2'h0, 16'h0000);
        chk(got, 16'h0024);
        par(1'b1, 1'b0, 2'h2, 16'h00FF);
        rreg(16'h0024, 16'h0085, 1'b0);
        i_mem_busy <= 1'b1;
        par(1'b0, 1'b0, 2'h1, 16'h0000);
        chk(got, 16'h0001);
        par(1'b0, 1'b0, 2'h3, 16'h0000);
        chk(got, 16'h0000);
        wreg(16'h0462, 16'h000A);
        wreg(16'h0028, 16'h0003);
        {i_mem_busy, stall} <= 2'h1;
        par(1'b1, 1'b0, 2'h0, 16'h1000);
        par(1'b0, 1'b1, 2'h2, 16'h0000);
        chk({15'h0, o_host_int}, 16'h0001);
        rreg(16'h0026, 16'h0001, 1'b0);
        wreg(16'h0026, 16'h0001);
        rreg(16'h0026, 16'h0000, 1'b0);
        wreg(16'h0020, 16'h0001);
        chk({15'h0, o_host_int}, 16'h0000);
        wreg(16'h0472, 16'h0000);
        wreg(16'h0100, 16'h0000);
        rreg(16'h0472, 16'h0004, 1'b0);
        wreg(16'h0472, 16'h0003);
        rreg(16'h0472, 16'h0003, 1'b0);
        stall <= 1'b0;
        rreg(16'h1000, 16'h0800, 1'b1);
        n0 = reqs;
        rreg(16'h1002, 16'h0801, 1'b1);
        chk(reqs, n0);
        rreg(16'h1002, 16'h0801, 1'b1);
        chk(reqs, n0 + 16'h1);
        {i_reset, i_config_straps, i_mem_busy} <= {1'b1, 9'h018, 1'b1};
        repeat (4) @(posedge i_clock);
        i_reset <= 1'b0;
        repeat (8) @(posedge i_clock);
        {i_config_straps, i_serial_select_n} <= {9'h004, 1'b0};
        repeat (8) @(posedge i_clock);
        sword(1'b0, 16'hC000);
        sword(1'b0, 16'h8000);
        chk(got, 16'h0001);
        i_serial_select_n <= 1'b1;
        repeat (8) @(posedge i_clock);
        test_done();
    end
endmodule
`default_nettype wire
